/* hdl/rtcf_consts.vh */
// constants for the rtc flag, stop and sub-second block
`ifndef RTCF_CONSTS_VH
`define RTCF_CONSTS_VH
`define RTCF_CLK_KHZ 25000
`define RTCF_OSC_HALT_MS 10
`define RTCF_INT_PULSE_US 7812
`define RTCF_ADDR_SEC 8'h00
`define RTCF_ADDR_MIN 8'h01
`define RTCF_ADDR_HOUR 8'h02
`define RTCF_ADDR_FLAGS 8'h0e
`define RTCF_ADDR_CTRL 8'h0f
`define RTCF_ADDR_FRAC_LO 8'h10
`define RTCF_ADDR_FRAC_HI 8'h11
`define RTCF_ADDR_SEC_ALIAS 8'h12
`define RTCF_ADDR_MIN_ALIAS 8'h13
`define RTCF_ADDR_HOUR_ALIAS 8'h14
`define RTCF_CTRL_RESET 8'h40
`define RTCF_BIT_POR 7
`define RTCF_BIT_OSC 6
`define RTCF_BIT_UPD 5
`define RTCF_BIT_WAKE 4
`define RTCF_BIT_ALARM 3
`define RTCF_BIT_EVENT 2
`define RTCF_BIT_ABN 1
`define RTCF_BIT_VLOW 0
`define RTCF_BIT_STOP 0
`define RTCF_FIELD_INTERVAL 7:6
`define RTCF_FIELD_FRAC_LO 7:6
`define RTCF_FIELD_CTRL_RW 7:2
`define RTCF_FIELD_FRAC_TOP 9:2
`define RTCF_FIELD_FRAC_BOT 1:0
`define RTCF_BIT_FRAC_MSB 9
`define RTCF_INTERVAL_RESET 2'h1
`define RTCF_MASK_SEC 8'h7f
`define RTCF_MASK_MIN 8'h7f
`define RTCF_MASK_HOUR 8'h3f
`define RTCF_SEC_LAST 8'h59
`define RTCF_MIN_LAST 8'h59
`define RTCF_HOUR_LAST 8'h23
`define RTCF_BCD_NINE 4'h9
`define RTCF_FRAC_LAST 10'h3ff
`define RTCF_FREQ_OUTPUT_PIN_32K 2'h0
`define RTCF_FREQ_OUTPUT_PIN_1K 2'h1
`define RTCF_FREQ_OUTPUT_PIN_1HZ 2'h2
`endif

/* hdl/rtcf_core.v */
// flags, stop control, sub-second counter and time aliases
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "rtcf_consts.vh"
// Function
// - writing 0 clears update, wake, alarm flags; event flag and ones ignored
// - clearing update, wake or alarm flag releases the interrupt pin
// - update and wake interrupt lows end after fixed time; flags stay
// - event summary flag is the OR of event and buffer flags
// - event summary falls only when all those clear, releasing interrupt
// - abnormality reads 1 with por or osc flag; clear needs both gone
// - low supply history sets on drop; clear only with supply normal
// - bits 7-6 select temperature measure interval, default 2.0 s
// - enable bits 5..2 gate interrupts; writing 0 clears that output
// - stop bit 0 halts counters when 1; reads 1 while idle; the code reads back the stored bit, 0 after reset
// - stopped freezes counters; no update or alarm interrupts
// - time stamp takes the time frozen at the stop
// - stop halts the wake timer and its interrupt
// - stopped 1 Hz output static; 32.768 kHz and 1024 Hz keep running
// - 10-bit sub-second counter in 1/1024 s units
// - low two bits in fraction low bits 7-6, upper eight in high
// - both fraction registers then 0x12..0x14 accessible back to back
// - writing seconds at 0x00 resets the sub-second counter
// - writing seconds alias 0x12 keeps the sub-second counter
// - seconds alias is bcd, tens 6-4, units 3-0, bit 7 zero
// - minutes alias 0x13 bcd, tens 6-4, units 3-0
// - hours alias 0x14 bcd, tens 5-4, units 3-0, bits 7-6 zero
// - flag bits 5,4,3,2 read 1 once their event has occurred
// - oscillator halt flag sets after 10 ms without oscillation
module rtcf_core #(
   parameter OSC_HALT_CYCLES = `RTCF_OSC_HALT_MS * `RTCF_CLK_KHZ,
   parameter INT_PULSE_CYCLES = (`RTCF_INT_PULSE_US * `RTCF_CLK_KHZ) / 1000
) (
   input wire clock,
   input wire rst,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [7:0] rdata,
   input wire tick_count,
   input wire tick_32k_half,
   input wire tick_1k_half,
   input wire [1:0] freq_output_pin_sel,
   input wire wake_event,
   input wire alarm_event,
   input wire [15:0] event_flags,
   input wire por_active,
   input wire osc_ok_pin,
   input wire supply_low_pin,
   input wire ts_capture,
   output reg [23:0] ts_time,
   output reg counters_stopped,
   output reg [1:0] temp_measure_interval,
   output reg freq_output_pin,
   output reg int_n_out,
   output reg int_n_oe
);
   function [7:0] bcd_next;
      input [7:0] v;
      input [7:0] last;
      begin
         if (v == last) begin
            bcd_next = 8'h00;
         end else if (v[3:0] == `RTCF_BCD_NINE) begin
            bcd_next = {v[7:4] + 4'h1, 4'h0};
         end else begin
            bcd_next = v + 8'h01;
         end
      end
   endfunction

   // write-0 clear request; ones written to a flag bit are ignored
   function clear_hit;
      input wr;
      input [7:0] d;
      input integer pos;
      begin
         clear_hit = wr & ~d[pos];
      end
   endfunction

   reg [9:0] frac_reg;
   reg [7:0] sec_reg;
   reg [7:0] min_reg;
   reg [7:0] hour_reg;
   reg [7:0] ctrl_reg;
   reg por_flag_reg, osc_flag_reg, upd_flag_reg, wake_flag_reg, alarm_flag_reg;
   reg abn_flag_reg, vlow_flag_reg;
   reg [19:0] osc_cnt_reg;
   reg osc_meta_reg, osc_sync_reg, vlow_meta_reg, vlow_sync_reg;

   wire stop = ctrl_reg[`RTCF_BIT_STOP];
   wire wr_flags = wr_en && addr == `RTCF_ADDR_FLAGS;
   wire wr_ctrl = wr_en && addr == `RTCF_ADDR_CTRL;
   wire run_tick = tick_count && !stop;
   wire sec_carry = run_tick && frac_reg == `RTCF_FRAC_LAST;
   wire min_carry = sec_carry && sec_reg == `RTCF_SEC_LAST;
   wire hour_carry = min_carry && min_reg == `RTCF_MIN_LAST;
   // no update or alarm event while stopped
   wire upd_event = sec_carry;
   wire alarm_set = alarm_event && !stop;
   wire wake_set = wake_event && !stop;
   // summary is the or of all event flags
   wire event_summary_flag = |event_flags;
   wire osc_halt_seen = osc_cnt_reg == OSC_HALT_CYCLES[19:0];
   wire upd_clr = clear_hit(wr_flags, wdata, `RTCF_BIT_UPD);
   wire wake_clr = clear_hit(wr_flags, wdata, `RTCF_BIT_WAKE);
   wire uie_off = clear_hit(wr_ctrl, wdata, `RTCF_BIT_UPD);
   wire tie_off = clear_hit(wr_ctrl, wdata, `RTCF_BIT_WAKE);
   wire upd_pulse, wake_pulse;
   // a disabling write or a flag clear ends a pulse early
   wire upd_cancel = upd_clr || uie_off;
   wire wake_cancel = wake_clr || tie_off;
   wire upd_start = upd_event && ctrl_reg[`RTCF_BIT_UPD];
   wire wake_start = wake_set && ctrl_reg[`RTCF_BIT_WAKE];

   // self-ending low for the update interrupt
   rtcf_pulse_timer #(.LEN(INT_PULSE_CYCLES[19:0])) upd_timer (
      .clock(clock),
      .rst(rst),
      .start(upd_start),
      .cancel(upd_cancel),
      .active(upd_pulse)
   );

   // self-ending low for the wake interrupt
   rtcf_pulse_timer #(.LEN(INT_PULSE_CYCLES[19:0])) wake_timer (
      .clock(clock),
      .rst(rst),
      .start(wake_start),
      .cancel(wake_cancel),
      .active(wake_pulse)
   );

   // pins come from outside the clock domain
   always @(posedge clock) begin
      if (rst) begin
         osc_meta_reg <= 1'b0;
         osc_sync_reg <= 1'b0;
         vlow_meta_reg <= 1'b0;
         vlow_sync_reg <= 1'b0;
      end else begin
         osc_meta_reg <= osc_ok_pin;
         osc_sync_reg <= osc_meta_reg;
         vlow_meta_reg <= supply_low_pin;
         vlow_sync_reg <= vlow_meta_reg;
      end
   end

   // count absence, saturate at the halt time
   always @(posedge clock) begin
      if (rst) begin
         osc_cnt_reg <= 20'h00000;
      end else if (osc_sync_reg) begin
         osc_cnt_reg <= 20'h00000;
      end else if (!osc_halt_seen) begin
         osc_cnt_reg <= osc_cnt_reg + 20'd1;
      end
   end

   // time counters; a write in the same cycle wins over the count
   always @(posedge clock) begin
      if (rst) begin
         frac_reg <= 10'h000;
         sec_reg <= 8'h00;
         min_reg <= 8'h00;
         hour_reg <= 8'h00;
      end else begin
         if (run_tick) begin
            frac_reg <= frac_reg + 10'h001;
         end
         if (sec_carry) begin
            sec_reg <= bcd_next(sec_reg, `RTCF_SEC_LAST);
         end
         if (min_carry) begin
            min_reg <= bcd_next(min_reg, `RTCF_MIN_LAST);
         end
         if (hour_carry) begin
            hour_reg <= bcd_next(hour_reg, `RTCF_HOUR_LAST);
         end
         if (wr_en) begin
            case (addr)
               `RTCF_ADDR_SEC: begin
                  sec_reg <= wdata & `RTCF_MASK_SEC;
                  // primary seconds write clears the fraction
                  frac_reg <= 10'h000;
               end
               // alias write leaves the fraction alone
               `RTCF_ADDR_SEC_ALIAS: begin
                  sec_reg <= wdata & `RTCF_MASK_SEC;
               end
               `RTCF_ADDR_MIN, `RTCF_ADDR_MIN_ALIAS: begin
                  min_reg <= wdata & `RTCF_MASK_MIN;
               end
               `RTCF_ADDR_HOUR, `RTCF_ADDR_HOUR_ALIAS: begin
                  hour_reg <= wdata & `RTCF_MASK_HOUR;
               end
               // low two fraction bits sit in 7-6
               `RTCF_ADDR_FRAC_LO: begin
                  frac_reg[`RTCF_FIELD_FRAC_BOT] <= wdata[`RTCF_FIELD_FRAC_LO];
               end
               `RTCF_ADDR_FRAC_HI: begin
                  frac_reg[`RTCF_FIELD_FRAC_TOP] <= wdata;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // control register
   always @(posedge clock) begin
      if (rst) begin
         ctrl_reg <= `RTCF_CTRL_RESET;
      end else if (wr_ctrl) begin
         // interval, enables and stop stored; bit 1 reads 0
         ctrl_reg <= {wdata[`RTCF_FIELD_CTRL_RW], 1'b0, wdata[`RTCF_BIT_STOP]};
      end
   end

   // interrupt flags: every hardware set wins over a software clear
   always @(posedge clock) begin
      if (rst) begin
         upd_flag_reg <= 1'b0;
         wake_flag_reg <= 1'b0;
         alarm_flag_reg <= 1'b0;
      end else begin
         upd_flag_reg <= upd_event | (upd_flag_reg & ~upd_clr);
         wake_flag_reg <= wake_set | (wake_flag_reg & ~wake_clr);
         alarm_flag_reg <= alarm_set |
            (alarm_flag_reg & ~clear_hit(wr_flags, wdata, `RTCF_BIT_ALARM));
      end
   end

   // self-monitoring flags set at power-up; a live cause blocks the clear
   always @(posedge clock) begin
      if (rst) begin
         por_flag_reg <= 1'b1;
         osc_flag_reg <= 1'b1;
         abn_flag_reg <= 1'b1;
         vlow_flag_reg <= 1'b1;
      end else begin
         por_flag_reg <= por_active |
            (por_flag_reg & ~clear_hit(wr_flags, wdata, `RTCF_BIT_POR));
         // set once absence reaches 10 ms
         osc_flag_reg <= osc_halt_seen |
            (osc_flag_reg & ~clear_hit(wr_flags, wdata, `RTCF_BIT_OSC));
         // clear only with por released and oscillator present
         abn_flag_reg <= por_active | osc_halt_seen | por_flag_reg | osc_flag_reg |
            (abn_flag_reg & ~clear_hit(wr_flags, wdata, `RTCF_BIT_ABN));
         // clear only while supply is normal
         vlow_flag_reg <= vlow_sync_reg |
            (vlow_flag_reg & ~clear_hit(wr_flags, wdata, `RTCF_BIT_VLOW));
      end
   end

   // register read, answered one cycle later; unmapped reads 0
   always @(posedge clock) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            `RTCF_ADDR_SEC, `RTCF_ADDR_SEC_ALIAS: begin
               rdata <= sec_reg;
            end
            `RTCF_ADDR_MIN, `RTCF_ADDR_MIN_ALIAS: begin
               rdata <= min_reg;
            end
            `RTCF_ADDR_HOUR, `RTCF_ADDR_HOUR_ALIAS: begin
               rdata <= hour_reg;
            end
            `RTCF_ADDR_FLAGS: begin
               // abnormality also follows the live flags
               rdata <= {por_flag_reg, osc_flag_reg, upd_flag_reg, wake_flag_reg,
                  alarm_flag_reg, event_summary_flag,
                  abn_flag_reg | por_flag_reg | osc_flag_reg, vlow_flag_reg};
            end
            `RTCF_ADDR_CTRL: begin
               // stop bit reads back the stored value, 0 after reset
               rdata <= ctrl_reg;
            end
            // fraction halves, any order, back to back
            `RTCF_ADDR_FRAC_LO: begin
               rdata <= {frac_reg[`RTCF_FIELD_FRAC_BOT], 6'h00};
            end
            `RTCF_ADDR_FRAC_HI: begin
               rdata <= frac_reg[`RTCF_FIELD_FRAC_TOP];
            end
            default: begin
               rdata <= 8'h00;
            end
         endcase
      end
   end

   // interrupt pin, outputs and time stamp
   always @(posedge clock) begin
      if (rst) begin
         int_n_out <= 1'b0;
         int_n_oe <= 1'b0;
         ts_time <= 24'h000000;
         counters_stopped <= 1'b0;
         temp_measure_interval <= `RTCF_INTERVAL_RESET;
         freq_output_pin <= 1'b0;
      end else begin
         int_n_out <= 1'b0;
         // open drain low only for an enabled live source
         int_n_oe <= upd_pulse | wake_pulse |
            (alarm_flag_reg & ctrl_reg[`RTCF_BIT_ALARM]) |
            (event_summary_flag & ctrl_reg[`RTCF_BIT_EVENT]);
         // capture sees the frozen time while stopped
         if (ts_capture) begin
            ts_time <= {hour_reg, min_reg, sec_reg};
         end
         counters_stopped <= stop;
         temp_measure_interval <= ctrl_reg[`RTCF_FIELD_INTERVAL];
         // 1 Hz follows the frozen fraction; fast rates keep toggling
         case (freq_output_pin_sel)
            `RTCF_FREQ_OUTPUT_PIN_32K: begin
               freq_output_pin <= freq_output_pin ^ tick_32k_half;
            end
            `RTCF_FREQ_OUTPUT_PIN_1K: begin
               freq_output_pin <= freq_output_pin ^ tick_1k_half;
            end
            `RTCF_FREQ_OUTPUT_PIN_1HZ: begin
               freq_output_pin <= ~frac_reg[`RTCF_BIT_FRAC_MSB];
            end
            default: begin
               freq_output_pin <= 1'b0;
            end
         endcase
      end
   end
endmodule

/* hdl/rtcf_pulse_timer.v */
// one-shot low-pulse timer for a self-ending interrupt
`timescale 1ns/1ps
module rtcf_pulse_timer #(
   parameter [19:0] LEN = 20'd1
) (
   input wire clock,
   input wire rst,
   input wire start,
   input wire cancel,
   output reg active
);
   reg [19:0] count_reg;
   always @(posedge clock) begin
      if (rst) begin
         active <= 1'b0;
         count_reg <= 20'h00000;
      end else if (cancel) begin
         active <= 1'b0;
         count_reg <= 20'h00000;
      end else if (start) begin
         active <= 1'b1;
         count_reg <= 20'h00000;
      end else if (active) begin
         if (count_reg == LEN - 20'd1) begin
            active <= 1'b0;
         end
         count_reg <= count_reg + 20'd1;
      end
   end
endmodule

/* sim/rtcf_core_monitor.sv */
// assertion checker for the rtc flag, stop and sub-second core
`timescale 1ns/1ps
module rtcf_core_monitor (
   input wire clock,
   input wire rst,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] rdata,
   input wire [15:0] event_flags,
   input wire [1:0] freq_output_pin_sel,
   input wire counters_stopped,
   input wire [1:0] temp_measure_interval,
   input wire freq_output_pin,
   input wire int_n_oe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // copies lag the control register by one cycle
   wire ctl_wr = wr_en && addr == 8'h0f;
   wire flg_rd = rd_en && addr == 8'h0e;
   chk_stop_copy: assert property (
      ctl_wr |-> ##2 counters_stopped == $past(wdata[0], 2))
      else $error("stop copy wrong");
   chk_interval_copy: assert property (
      ctl_wr |-> ##2 temp_measure_interval == $past(wdata[7:6], 2))
      else $error("interval copy wrong");
   chk_stop_readback: assert property (
      rd_en && addr == 8'h0f |=> rdata[1:0] == {1'b0, counters_stopped})
      else $error("stop readback wrong");
   chk_frac_low_zero: assert property (
      rd_en && addr == 8'h10 |=> rdata[5:0] == 6'h00)
      else $error("fraction low bits not zero");
   chk_sec_alias_top: assert property (
      rd_en && addr == 8'h12 |=> !rdata[7])
      else $error("seconds alias bit 7 set");
   chk_hour_alias_top: assert property (
      rd_en && addr == 8'h14 |=> rdata[7:6] == 2'h0)
      else $error("hours alias top bits set");
   chk_abn_follows: assert property (
      flg_rd |=> !(rdata[7] || rdata[6]) || rdata[1])
      else $error("abnormality flag low");
   chk_event_summary: assert property (
      flg_rd && $stable(event_flags) |=> rdata[2] == (|$past(event_flags)))
      else $error("event summary wrong");
   chk_irq_disable: assert property (
      ctl_wr && wdata[5:2] == 4'h0 |-> ##2 !int_n_oe)
      else $error("interrupt kept after disable");
   chk_unmapped_zero: assert property (
      rd_en && addr[7:5] != 3'h0 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_freq_output_pin_static: assert property (
      (counters_stopped && freq_output_pin_sel == 2'h2 && !wr_en) [*3] |=> $stable(freq_output_pin))
      else $error("1 Hz output moved while stopped");
endmodule
bind rtcf_core rtcf_core_monitor u_mon (.clock, .rst, .addr, .wdata, .wr_en, .rd_en,
   .rdata, .event_flags, .freq_output_pin_sel, .counters_stopped, .temp_measure_interval,
   .freq_output_pin, .int_n_oe);

/* sim/tb.sv */
// self-checking bench for the rtc flag, stop and sub-second core
`timescale 1ns/1ps
module tb;
   localparam [7:0] PULSE = 8'h08;
   reg clock = 1'b0;
   reg rst = 1'b1;
   reg [7:0] addr = 8'h00;
   reg [7:0] wdata = 8'h00;
   reg wr_en = 1'b0;
   reg rd_en = 1'b0;
   reg tick_count = 1'b0;
   reg tick_32k_half = 1'b0;
   reg tick_1k_half = 1'b0;
   reg [1:0] freq_output_pin_sel = 2'h2;
   reg wake_event = 1'b0;
   reg alarm_event = 1'b0;
   reg [15:0] event_flags = 16'h0000;
   reg por_active = 1'b1;
   reg osc_ok_pin = 1'b1;
   reg supply_low_pin = 1'b0;
   reg ts_capture = 1'b0;
   wire [7:0] rdata;
   wire [23:0] ts_time;
   wire counters_stopped;
   wire [1:0] temp_measure_interval;
   wire freq_output_pin;
   wire int_n_out;
   wire int_n_oe;
   integer n_mismatch = 0;
   integer tests_run = 0;
   integer cycles = 0;
   integer i;
   reg [7:0] cnt;
   reg f0;
   always #20 clock = ~clock;
   // short counts keep the halt and pulse tests brief
   rtcf_core #(.OSC_HALT_CYCLES(20), .INT_PULSE_CYCLES(8)) DUT (.clock, .rst, .addr, .wdata,
      .wr_en, .rd_en, .rdata, .tick_count, .tick_32k_half, .tick_1k_half, .freq_output_pin_sel,
      .wake_event, .alarm_event, .event_flags, .por_active, .osc_ok_pin, .supply_low_pin,
      .ts_capture, .ts_time, .counters_stopped, .temp_measure_interval, .freq_output_pin,
      .int_n_out, .int_n_oe);
   task check(input [7:0] got, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task chb(input b, input e);
      check({7'h00, b}, {7'h00, e});
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr_en <= 1'b1;
         @(posedge clock);
         wr_en <= 1'b0;
         @(posedge clock);
         #1;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         addr <= a;
         rd_en <= 1'b1;
         @(posedge clock);
         rd_en <= 1'b0;
         #1;
         check(rdata, e);
         @(posedge clock);
         #1;
      end
   endtask
   // back-to-back reads from the low fraction byte up to the hour alias
   task burst(input [39:0] e);
      begin
         for (i = 0; i < 5; i = i + 1) begin
            addr <= 8'h10 + i[7:0];
            rd_en <= 1'b1;
            @(posedge clock);
            #1;
            check(rdata, e[8*i +: 8]);
         end
         rd_en <= 1'b0;
         cyc(1);
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clock);
         #1;
      end
   endtask
   // one strobe: tick, wake, alarm, capture, 32k half, 1k half
   task pl(input [5:0] m);
      begin
         {tick_count, wake_event, alarm_event, ts_capture, tick_32k_half, tick_1k_half} <= m;
         @(posedge clock);
         {tick_count, wake_event, alarm_event, ts_capture, tick_32k_half, tick_1k_half} <= 6'h00;
         cyc(1);
      end
   endtask
   task close_out;
      begin
         $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
         if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch = n_mismatch + 1;
         close_out;
      end
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      cyc(1);
      check({6'h00, temp_measure_interval}, 8'h01);
      rd(8'h0f, 8'h40);
      rd(8'h0e, 8'hc3);
      rd(8'h40, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h0f, {i[1:0], 6'h00});
         check({6'h00, temp_measure_interval}, {6'h00, i[1:0]});
      end
      wr(8'h0e, 8'h00);
      rd(8'h0e, 8'h82);
      por_active <= 1'b0;
      wr(8'h0e, 8'h00);
      rd(8'h0e, 8'h02);
      wr(8'h0e, 8'h00);
      rd(8'h0e, 8'h00);
      supply_low_pin <= 1'b1;
      cyc(4);
      wr(8'h0e, 8'h00);
      rd(8'h0e, 8'h01);
      supply_low_pin <= 1'b0;
      cyc(4);
      wr(8'h0e, 8'hff);
      rd(8'h0e, 8'h01);
      wr(8'h0e, 8'h00);
      rd(8'h0e, 8'h00);
      osc_ok_pin <= 1'b0;
      cyc(30);
      wr(8'h0e, 8'h00);
      rd(8'h0e, 8'h42);
      osc_ok_pin <= 1'b1;
      cyc(4);
      wr(8'h0e, 8'h00);
      wr(8'h0e, 8'h00);
      rd(8'h0e, 8'h00);
      wr(8'h11, 8'hff);
      wr(8'h00, 8'h59);
      rd(8'h11, 8'h00);
      wr(8'h13, 8'h59);
      wr(8'h14, 8'h23);
      wr(8'h11, 8'hff);
      wr(8'h10, 8'hff);
      rd(8'h10, 8'hc0);
      wr(8'h12, 8'h59);
      rd(8'h11, 8'hff);
      wr(8'h0f, 8'h20);
      pl(6'h20);
      cnt = 8'h00;
      repeat (20) begin
         if (int_n_oe === 1'b1)
            cnt = cnt + 8'h01;
         cyc(1);
      end
      check(cnt, PULSE);
      rd(8'h0e, 8'h20);
      rd(8'h11, 8'h00);
      rd(8'h12, 8'h00);
      rd(8'h13, 8'h00);
      rd(8'h14, 8'h00);
      pl(6'h20);
      rd(8'h10, 8'h40);
      wr(8'h0e, 8'hdf);
      rd(8'h0e, 8'h00);
      wr(8'h14, 8'hd2);
      wr(8'h13, 8'hb4);
      wr(8'h12, 8'hd6);
      rd(8'h02, 8'h12);
      rd(8'h01, 8'h34);
      rd(8'h00, 8'h56);
      burst(40'h1234560040);
      wr(8'h0f, 8'h19);
      rd(8'h0f, 8'h19);
      pl(6'h20);
      pl(6'h10);
      pl(6'h08);
      pl(6'h04);
      rd(8'h10, 8'h40);
      rd(8'h0e, 8'h00);
      chb(int_n_oe, 1'b0);
      check(ts_time[23:16], 8'h12);
      check(ts_time[15:0] == 16'h3456, 8'h01);
      chb(freq_output_pin, 1'b1);
      for (i = 0; i < 2; i = i + 1) begin
         freq_output_pin_sel <= i[1:0];
         cyc(3);
         f0 = freq_output_pin;
         pl(i == 0 ? 6'h02 : 6'h01);
         chb(freq_output_pin, ~f0);
      end
      freq_output_pin_sel <= 2'h3;
      cyc(2);
      chb(freq_output_pin, 1'b0);
      wr(8'h0f, 8'h18);
      pl(6'h10);
      chb(int_n_oe, 1'b1);
      chb(int_n_out, 1'b0);
      cyc(12);
      chb(int_n_oe, 1'b0);
      pl(6'h08);
      rd(8'h0e, 8'h18);
      chb(int_n_oe, 1'b1);
      wr(8'h0e, 8'hf7);
      chb(int_n_oe, 1'b0);
      rd(8'h0e, 8'h10);
      pl(6'h08);
      wr(8'h0f, 8'h10);
      chb(int_n_oe, 1'b0);
      wr(8'h0f, 8'h04);
      event_flags <= 16'h0100;
      cyc(3);
      chb(int_n_oe, 1'b1);
      wr(8'h0e, 8'h00);
      rd(8'h0e, 8'h04);
      event_flags <= 16'h0000;
      cyc(3);
      rd(8'h0e, 8'h00);
      chb(int_n_oe, 1'b0);
      close_out;
   end
endmodule
